// file: hdl/tcs_queue_status.sv
// Task clear, status query scheduling and response capture for the queue engine.
// Assumes halt, pending and transfer inputs come from logic on pclk; timer_clk is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_map.svh"

module tcs_queue_status
    import tcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic engine_halted,
    input wire logic [31:0] pending_tasks,
    input wire logic timer_clk,
    input wire logic xfer_active,
    input wire logic [15:0] transaction_block_count,
    input wire logic [15:0] xfer_block_idx,
    output logic query_req,
    output logic [31:0] query_arg,
    input wire logic query_ack,
    input wire logic status_rsp_valid,
    input wire logic [31:0] status_rsp_word,
    input wire logic direct_rsp_valid,
    input wire logic [31:0] direct_rsp_data,
    output logic [31:0] doorbell_clear,
    output logic clear_busy
);

    // ************************************************************
    // state
    // ************************************************************
    tcs_state_t st_q;
    tcs_state_t st_d;

    logic acc_done;
    logic wr_en;
    logic tmr_edge;
    logic [16:0] blk_target;
    logic blk_hit;
    logic [15:0] idle_load;

    assign acc_done = psel & penable & st_q.pready;
    assign wr_en = acc_done & pwrite;
    assign tmr_edge = st_q.tmr_s2 & ~st_q.tmr_s3;
    assign blk_target = {1'b0, transaction_block_count} - {13'h0, st_q.blk_countdown};
    // zero-based block index: countdown one lands on the final block
    assign blk_hit = ~blk_target[16] && (blk_target[15:0] == xfer_block_idx);
    // a zero period would wrap to the longest wait, so it is held to the minimum
    assign idle_load = (st_q.idle_period == 16'h0) ? `TCS_IDLE_MIN : st_q.idle_period;

    function automatic logic [4:0] lowest_bit(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.db_clear = 32'h0;
        st_d.tmr_s1 = timer_clk;
        st_d.tmr_s2 = st_q.tmr_s1;
        st_d.tmr_s3 = st_q.tmr_s2;

        // apb: no wait states, answer registered in the setup cycle
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        if (psel && !penable) begin
            st_d.pready = 1'b1;
            case (paddr)
                `TCS_OFS_QUEUE_STATUS: st_d.prdata = st_q.queue_status;
                `TCS_OFS_PENDING: st_d.prdata = pending_tasks;
                `TCS_OFS_TASK_CLEAR: st_d.prdata = st_q.task_clear;
                `TCS_OFS_STATUS_SCHED: st_d.prdata = {12'h0, st_q.blk_countdown, st_q.idle_period};
                `TCS_OFS_STATUS_ADDR: st_d.prdata = {16'h0, st_q.card_addr};
                `TCS_OFS_DIRECT_RSP: st_d.prdata = st_q.direct_rsp;
                default: begin
                    st_d.prdata = 32'h0;
                    st_d.pslverr = 1'b1;
                end
            endcase
        end

        if (wr_en) begin
            case (paddr)
                `TCS_OFS_TASK_CLEAR: begin
                    // only one removal at a time; extra bits in one write are dropped
                    if (engine_halted && !st_q.clr_busy && pwdata != 32'h0) begin
                        st_d.clr_idx = lowest_bit(pwdata);
                        st_d.task_clear = 32'h1 << lowest_bit(pwdata);
                        st_d.clr_busy = 1'b1;
                        st_d.clr_cnt = `TCS_CLEAR_CYCLES;
                    end
                end
                `TCS_OFS_STATUS_SCHED: begin
                    st_d.blk_countdown = pwdata[`TCS_CD_MSB:`TCS_CD_LSB];
                    st_d.idle_period = pwdata[`TCS_IDLE_MSB:`TCS_IDLE_LSB];
                end
                `TCS_OFS_STATUS_ADDR: st_d.card_addr = pwdata[15:0];
                default: ;
            endcase
        end

        // ************************************************************
        // task removal: internal only, nothing goes to the memory
        // ************************************************************
        if (st_q.clr_busy) begin
            st_d.clr_cnt = st_q.clr_cnt - 3'h1;
            if (st_q.clr_cnt == 3'h1) begin
                st_d.clr_busy = 1'b0;
                st_d.task_clear = 32'h0;
                st_d.db_clear = 32'h1 << st_q.clr_idx;
            end
        end

        // ************************************************************
        // status query scheduling
        // ************************************************************
        if (st_q.query_req && query_ack) begin
            st_d.query_req = 1'b0;
        end
        if (!xfer_active) begin
            st_d.blk_sent = 1'b0;
        end

        // countdown zero never fires during data, leaving it to the idle path
        if (xfer_active && st_q.blk_countdown != 4'h0 && !st_q.blk_sent && blk_hit) begin
            st_d.blk_sent = 1'b1;
            st_d.query_req = 1'b1;
            st_d.query_arg = {st_q.card_addr, 16'h0};
        end

        if (st_q.tmr_run && tmr_edge) begin
            st_d.tmr_cnt = st_q.tmr_cnt - 16'h1;
            if (st_q.tmr_cnt == 16'h1) begin
                st_d.tmr_run = 1'b0;
                st_d.query_req = 1'b1;
                st_d.query_arg = {st_q.card_addr, 16'h0};
            end
        end

        if (status_rsp_valid) begin
            st_d.queue_status = status_rsp_word;
            if (status_rsp_word == 32'h0 && pending_tasks != 32'h0 && !xfer_active) begin
                st_d.tmr_run = 1'b1;
                st_d.tmr_cnt = idle_load;
            end
        end

        // stopped timer restarts from the full period on the next not-ready status
        if (pending_tasks == 32'h0 || xfer_active) begin
            st_d.tmr_run = 1'b0;
        end

        if (direct_rsp_valid) begin
            // software waits for doorbell bit 31 to clear before trusting this
            st_d.direct_rsp = direct_rsp_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.blk_countdown <= `TCS_CD_RST;
            st_q.idle_period <= `TCS_IDLE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign query_req = st_q.query_req;
    assign query_arg = st_q.query_arg;
    assign doorbell_clear = st_q.db_clear;
    assign clear_busy = st_q.clr_busy;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic tc_wr;
    assign tc_wr = wr_en && paddr == `TCS_OFS_TASK_CLEAR;

    logic sched_wr;
    logic addr_wr;
    assign sched_wr = wr_en && paddr == `TCS_OFS_STATUS_SCHED;
    assign addr_wr = wr_en && paddr == `TCS_OFS_STATUS_ADDR;

    clear_not_halted_a: assert property (
        tc_wr && !engine_halted && !st_q.clr_busy |=> $stable(st_q.task_clear) && !st_q.clr_busy)
        else $error("task clear changed while not halted");

    clear_zero_write_a: assert property (
        tc_wr && pwdata == 32'h0 && !st_q.clr_busy |=> $stable(st_q.task_clear))
        else $error("zero write changed task clear");

    clear_start_a: assert property (
        tc_wr && engine_halted && !st_q.clr_busy && pwdata != 32'h0
        |=> st_q.clr_busy && st_q.task_clear != 32'h0 && (st_q.task_clear & $past(pwdata)) == st_q.task_clear)
        else $error("task clear write not taken");

    clear_finish_a: assert property (
        $rose(st_q.clr_busy) |-> st_q.clr_busy [*4] ##1 (!st_q.clr_busy && st_q.task_clear == 32'h0
        && doorbell_clear != 32'h0))
        else $error("task removal did not finish in four cycles");

    clear_no_query_a: assert property (
        $rose(query_req) |-> $past(xfer_active) || $past(st_q.tmr_run))
        else $error("query issued without a scheduling cause");

    query_arg_addr_a: assert property (
        $rose(query_req) |-> query_arg[31:16] == $past(st_q.card_addr) && query_arg[15:0] == 16'h0)
        else $error("query argument lacks card address");

    countdown_zero_a: assert property (
        $rose(st_q.blk_sent) |-> $past(st_q.blk_countdown) != 4'h0)
        else $error("query sent during data with countdown zero");

    queue_status_upd_a: assert property (
        status_rsp_valid |=> st_q.queue_status == $past(status_rsp_word))
        else $error("queue status not updated");

    direct_rsp_upd_a: assert property (
        direct_rsp_valid |=> st_q.direct_rsp == $past(direct_rsp_data))
        else $error("direct response not captured");

    idle_timer_stop_a: assert property (
        pending_tasks == 32'h0 || xfer_active |=> !st_q.tmr_run)
        else $error("idle timer ran without pending tasks or during transfer");

    idle_timer_load_a: assert property (
        status_rsp_valid && status_rsp_word == 32'h0 && pending_tasks != 32'h0 && !xfer_active
        |=> st_q.tmr_run && st_q.tmr_cnt == (($past(st_q.idle_period) == 16'h0) ? 16'h1 : $past(st_q.idle_period)))
        else $error("idle timer not loaded from period");

    clear_one_hot_a: assert property (
        $onehot0(st_q.task_clear))
        else $error("task clear holds more than one bit");

    clear_start_cnt_a: assert property (
        tc_wr && engine_halted && !st_q.clr_busy && pwdata != 32'h0
        |=> st_q.clr_cnt == `TCS_CLEAR_CYCLES)
        else $error("removal count not loaded");

    clear_hold_a: assert property (
        st_q.clr_busy && st_q.clr_cnt != 3'h1
        |=> $stable(st_q.task_clear) && st_q.clr_busy)
        else $error("task clear moved before removal finished");

    clear_busy_refuse_a: assert property (
        tc_wr && st_q.clr_busy
        |=> $stable(st_q.clr_idx))
        else $error("second removal taken while busy");

    doorbell_pulse_a: assert property (
        doorbell_clear != 32'h0
        |=> doorbell_clear == 32'h0)
        else $error("doorbell clear held longer than one cycle");

    doorbell_one_hot_a: assert property (
        doorbell_clear != 32'h0
        |-> $onehot(doorbell_clear) && !st_q.clr_busy && $past(st_q.clr_busy))
        else $error("doorbell clear without a finished removal");

    removal_no_query_a: assert property (
        st_q.clr_busy && !xfer_active && !st_q.tmr_run && !query_req
        |=> !query_req)
        else $error("removal raised a query");

    sched_write_a: assert property (
        sched_wr
        |=> {12'h0, st_q.blk_countdown, st_q.idle_period} == ($past(pwdata) & 32'h000F_FFFF))
        else $error("status schedule write not taken");

    addr_write_a: assert property (
        addr_wr
        |=> {16'h0, st_q.card_addr} == ($past(pwdata) & 32'h0000_FFFF))
        else $error("card address write not taken");

    query_hold_a: assert property (
        query_req && !query_ack
        |=> query_req)
        else $error("query request dropped before acknowledge");

    query_arg_low_a: assert property (
        query_req
        |-> query_arg[15:0] == 16'h0)
        else $error("query argument low half not zero");

    block_once_a: assert property (
        st_q.blk_sent && xfer_active
        |=> st_q.blk_sent)
        else $error("block trigger rearmed inside a transfer");

    block_hit_a: assert property (
        $rose(st_q.blk_sent)
        |-> $past(blk_hit) && $past(xfer_active) && query_req)
        else $error("block query off its block");

    countdown_zero_hold_a: assert property (
        xfer_active && st_q.blk_countdown == 4'h0 && !st_q.blk_sent
        |=> !st_q.blk_sent)
        else $error("countdown zero armed a block query");

    idle_fire_a: assert property (
        st_q.tmr_run && tmr_edge && st_q.tmr_cnt == 16'h1 && !status_rsp_valid
        |=> query_req && !st_q.tmr_run)
        else $error("expired idle timer raised no query");

    idle_step_a: assert property (
        st_q.tmr_run && !tmr_edge && !status_rsp_valid
        |=> st_q.tmr_cnt == $past(st_q.tmr_cnt))
        else $error("idle timer counted without a timer edge");

    idle_nonzero_a: assert property (
        st_q.tmr_run
        |-> st_q.tmr_cnt != 16'h0)
        else $error("idle timer running at zero");

    direct_hold_a: assert property (
        !direct_rsp_valid
        |=> $stable(st_q.direct_rsp))
        else $error("direct response changed without a response");

    queue_status_hold_a: assert property (
        !status_rsp_valid
        |=> $stable(st_q.queue_status))
        else $error("queue status changed without a response");

endmodule // tcs_queue_status
`default_nettype wire

// file: hdl/tcs_map.svh
// Register offsets, field positions, reset values and timing counts for the task clear and status query block.
// Assumes a 40 MHz pclk and a byte-addressed APB with 32-bit words.
// Operation
// - writing one to task clear bit n sets it and starts removing task n; the code takes only the lowest set bit of a write
// - when removal completes, bit n clears in task clear and task doorbell
// - task clear writes accepted only while the engine is halted
// - clearing a task touches engine state only, sends no command to the memory
// - a zero written to a task clear bit changes nothing
// - countdown n sends the status query during data block count minus n
// - countdown zero sends the status query only while data lines are idle
// - countdown one sends the status query during the final data block
// - with tasks pending and no transfer, wait the idle period after a not-ready status
// - idle period counts periods of the internal timer clock
// - idle period spans 0001h to FFFFh timer periods, default 4096
// - card address field goes into status query argument bits 31:16
// - each direct-command response loads the direct response register
// - direct response valid only after doorbell bit 31 has cleared
// - every status response updates the device queue status register
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

`define TCS_OFS_QUEUE_STATUS 8'h30
`define TCS_OFS_PENDING 8'h34
`define TCS_OFS_TASK_CLEAR 8'h38
`define TCS_OFS_STATUS_SCHED 8'h40
`define TCS_OFS_STATUS_ADDR 8'h44
`define TCS_OFS_DIRECT_RSP 8'h48

`define TCS_CD_MSB 19
`define TCS_CD_LSB 16
`define TCS_IDLE_MSB 15
`define TCS_IDLE_LSB 0
`define TCS_ARG_ADDR_LSB 16

`define TCS_CD_RST 4'h1
`define TCS_IDLE_RST 16'h1000
`define TCS_IDLE_MIN 16'h0001
`define TCS_CLEAR_CYCLES 3'h4

`endif

// file: hdl/tcs_pkg.sv
// Types for the task clear and status query block.
// Constants live in tcs_map.svh.
package tcs_pkg;

    typedef struct packed {
        logic [31:0] task_clear;
        logic clr_busy;
        logic [4:0] clr_idx;
        logic [2:0] clr_cnt;
        logic [31:0] db_clear;
        logic [3:0] blk_countdown;
        logic [15:0] idle_period;
        logic [15:0] card_addr;
        logic [31:0] direct_rsp;
        logic [31:0] queue_status;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic query_req;
        logic [31:0] query_arg;
        logic blk_sent;
        logic tmr_run;
        logic [15:0] tmr_cnt;
        logic tmr_s1;
        logic tmr_s2;
        logic tmr_s3;
    } tcs_state_t;

endpackage

// file: verif/tcs_flash_model.sv
// Far-side model of the flash device: answers each status query.
// Assumes the block's query handshake on pclk; dly sets a prompt or slow answer.
`timescale 1ns/1ps
`default_nettype none
module tcs_flash_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic query_req,
    input wire logic [31:0] query_arg,
    input wire logic [3:0] dly,
    input wire logic [31:0] rsp_word,
    output logic query_ack,
    output logic status_rsp_valid,
    output logic [31:0] status_rsp_word,
    output logic [31:0] last_arg
);
    logic busy;
    logic [3:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {busy, cnt, query_ack, status_rsp_valid, status_rsp_word, last_arg} <= '0;
        end else begin
            query_ack <= 1'b0;
            status_rsp_valid <= 1'b0;
            // word means nothing without its strobe, so it never holds
            status_rsp_word <= ~status_rsp_word;
            if (query_req && !busy && !query_ack) begin
                busy <= 1'b1;
                cnt <= dly;
                last_arg <= query_arg;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                query_ack <= 1'b1;
                status_rsp_valid <= 1'b1;
                status_rsp_word <= rsp_word;
            end
        end
    end
endmodule // tcs_flash_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for tcs_queue_status.
// Assumes tcs_flash_model on the query link and a free-running 200 ns timer clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, engine_halted = 1;
    logic xfer_active = 0, timer_clk = 0, direct_rsp_valid = 0, err, pready, pslverr;
    logic query_req, query_ack, status_rsp_valid, clear_busy;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, pending_tasks = 0, direct_rsp_data = 0, rsp_word = 0, db_seen = 0;
    logic [31:0] prdata, query_arg, doorbell_clear, status_rsp_word, last_arg, rd;
    logic [15:0] transaction_block_count = 5, xfer_block_idx = 0, hit;
    logic [3:0] dly = 0;
    int failures = 0, compares = 0, qcnt = 0;
    tcs_queue_status tcs_queue_status_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .engine_halted, .pending_tasks, .timer_clk, .xfer_active,
        .transaction_block_count, .xfer_block_idx, .query_req, .query_arg, .query_ack, .status_rsp_valid,
        .status_rsp_word, .direct_rsp_valid, .direct_rsp_data, .doorbell_clear, .clear_busy);
    tcs_flash_model tcs_flash_model_inst (.pclk, .presetn, .query_req, .query_arg, .dly, .rsp_word,
        .query_ack, .status_rsp_valid, .status_rsp_word, .last_arg);
    always #12.5 pclk = ~pclk;
    initial begin
        #7;
        forever #100 timer_clk = ~timer_clk;
    end
    always @(negedge pclk) db_seen |= doorbell_clear;
    always @(posedge query_req) qcnt++;
    // ********************
    // shared tasks
    // ********************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(rd, e);
    endtask
    task automatic run_xfer(input int cnt);
        hit = 16'hFFFF;
        @(posedge pclk);
        transaction_block_count <= cnt[15:0];
        xfer_active <= 1;
        for (int i = 0; i < cnt; i++) begin
            xfer_block_idx <= i[15:0];
            repeat (6) @(negedge pclk) if (query_req === 1'b1 && hit == 16'hFFFF) hit = i[15:0];
            @(posedge pclk);
        end
        xfer_active <= 0;
    endtask
    task automatic wait_rsp;
        int n = 0;
        while (status_rsp_valid !== 1'b1 && n < 100) begin
            @(negedge pclk);
            n++;
        end
        chk({31'h0, status_rsp_valid}, 1);
        @(negedge pclk);
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic t_regs;
        rdc(8'h38, 32'h0);
        rdc(8'h40, 32'h0001_1000);
        apb(1, 8'h40, 32'hFFFF_FFFF);
        rdc(8'h40, 32'h000F_FFFF);
        apb(1, 8'h48, 32'h0000_1234);
        rdc(8'h48, 32'h0);
        apb(0, 8'h3C, 0);
        chk({31'h0, err}, 1);
        $display("test regs done");
    endtask
    task automatic t_clear;
        int n = 0;
        int q0 = qcnt;
        engine_halted <= 0;
        apb(1, 8'h38, 32'h4);
        rdc(8'h38, 32'h0);
        engine_halted <= 1;
        pending_tasks <= 32'h4;
        rdc(8'h34, 32'h4);
        pending_tasks <= 32'h0;
        apb(1, 8'h38, 32'h0);
        rdc(8'h38, 32'h0);
        chk(db_seen, 32'h0);
        apb(1, 8'h38, 32'h4);
        rdc(8'h38, 32'h4);
        chk({31'h0, clear_busy}, 1);
        do begin
            apb(0, 8'h38, 0);
            n++;
        end while (rd !== 32'h0 && n < 10);
        chk(rd, 32'h0);
        chk({31'h0, clear_busy}, 0);
        chk(db_seen, 32'h4);
        chk(qcnt, q0);
        $display("test clear done");
    endtask
    task automatic t_block;
        apb(1, 8'h44, 32'h0000_ABCD);
        apb(1, 8'h40, 32'h0002_0003);
        rsp_word <= 32'h0000_005A;
        run_xfer(5);
        chk({16'h0, hit}, 3);
        chk(last_arg, 32'hABCD_0000);
        rdc(8'h30, 32'h0000_005A);
        apb(1, 8'h40, 32'h0001_0003);
        run_xfer(5);
        chk({16'h0, hit}, 4);
        apb(1, 8'h40, 32'h0000_0003);
        run_xfer(5);
        chk({16'h0, hit}, 32'h0000_FFFF);
        $display("test block done");
    endtask
    task automatic t_idle;
        int n = 0;
        int q0;
        // slow answer lands after the transfer, so the idle timer arms
        pending_tasks <= 32'h1;
        rsp_word <= 32'h0;
        dly <= 4'hF;
        apb(1, 8'h40, 32'h0001_0003);
        run_xfer(2);
        wait_rsp;
        while (query_req !== 1'b1 && n < 60) begin
            @(negedge pclk);
            n++;
        end
        chk({31'h0, n >= 14 && n <= 30}, 1);
        wait_rsp;
        @(posedge pclk);
        pending_tasks <= 32'h0;
        q0 = qcnt;
        repeat (60) @(negedge pclk);
        chk(qcnt, q0);
        $display("test idle done");
    endtask
    task automatic t_direct;
        @(posedge pclk);
        direct_rsp_valid <= 1;
        direct_rsp_data <= 32'hC0DE_0931;
        @(posedge pclk);
        direct_rsp_valid <= 0;
        direct_rsp_data <= 32'h3F21_F6CE;
        rdc(8'h48, 32'hC0DE_0931);
        $display("test direct done");
    endtask
    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_clear;
        t_block;
        t_idle;
        t_direct;
        conclude;
    end
    initial begin
        #200000;
        failures++;
        conclude;
    end
endmodule // tb
`default_nettype wire
